// ---- pkg/flash_frontend_pkg.sv ----
// Constants shared by the serial flash command front end
package flash_frontend_pkg;
    // Opcodes
    localparam logic [7:0] WRITE_UNLOCK_CMD = 8'h06;
    localparam logic [7:0] WRITE_LOCK_CMD   = 8'h04;
    localparam logic [7:0] JEDEC_ID_READ_CMD = 8'h9f;
    localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] READ_CMD         = 8'h03;
    localparam logic [7:0] FAST_READ_CMD    = 8'h0b;
    localparam logic [7:0] DUAL_IO_READ_CMD = 8'hbb;
    localparam logic [7:0] QUAD_IO_READ_CMD = 8'heb;

    // Array map
    localparam int          ADDR_BITS    = 24;
    localparam logic [23:0] ARRAY_LAST   = 24'h0fffff;
    localparam logic [23:0] SECTOR_SIZE  = 24'h001000;
    localparam int          SECTOR_SHIFT = 12;
    localparam int          BLOCK_SHIFT  = 16;
    localparam logic [7:0]  SECTOR_LAST  = 8'hff;

    // Serial framing
    localparam logic [5:0] BYTE_BITS      = 6'h08;
    localparam logic [5:0] ADDR_BITS_W    = 6'h18;
    localparam logic [3:0] LANES_SINGLE   = 4'h1;
    localparam logic [3:0] LANES_DUAL     = 4'h2;
    localparam logic [3:0] LANES_QUAD     = 4'h4;
    localparam logic [5:0] DUMMY_NONE     = 6'h00;
    localparam logic [5:0] DUMMY_FAST     = 6'h08;
    localparam logic [5:0] DUMMY_DUAL     = 6'h04;
    localparam logic [5:0] DUMMY_QUAD     = 6'h06;
    localparam logic [1:0] ID_LAST_INDEX  = 2'h2;

    // Synchroniser idle value for {chip_select_n, serial_clock, io[3:0]}
    localparam logic [5:0] PIN_IDLE = 6'h20;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_OPCODE   = 3'b001,
        ST_ADDRESS  = 3'b011,
        ST_DUMMY    = 3'b010,
        ST_DATA_OUT = 3'b110,
        ST_PAYLOAD  = 3'b111,
        ST_WAIT_END = 3'b101,
        ST_IGNORE   = 3'b100
    } frame_state_t;

    typedef enum logic [1:0] {
        SRC_ID     = 2'b00,
        SRC_STATUS = 2'b01,
        SRC_ARRAY  = 2'b11
    } byte_source_t;
endpackage : flash_frontend_pkg

// ---- hw/pin_filter.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
module pin_filter #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE  = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    always_comb begin
        level_next = (stage2_reg & stage3_reg) | (level_reg & (stage2_reg ^ stage3_reg));
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stage1_reg <= IDLE;
            stage2_reg <= IDLE;
            stage3_reg <= IDLE;
            level_reg  <= IDLE;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg  <= level_next;
        end
    end

    assign level = level_reg;
endmodule : pin_filter

// ---- hw/serial_flash_command_frontend.sv ----
// Command front end of a serial NOR flash: framing, decode, write latch and read data out
// How it works
// (RULE1) 1 MB array: 16 blocks, 256 4 KB sectors
// (RULE2) Unknown opcode ignores all until select falls
// (RULE3) Output pins released while in standby
// (RULE4) Known opcode keeps device active until select rises; a read opcode while array_busy goes to ST_IGNORE instead, not active
// (RULE5) Sample on clock rise, drive on fall
// (RULE6) Host may idle clock low or high
// (RULE7) Select rise ends read data at once
// (RULE8) Write-type commands need whole-byte frame end
// (RULE9) Array reads ignored while write operation busy
// (RULE10) Host polls status before issuing commands
// (RULE11) Identification returns one maker, two device bytes
// (RULE12) Write latch required before status write
// (RULE13) Latch cleared at reset and write completions
// (RULE14) Dual read: two bits per clock, MSB line one
// (RULE15) Decode nine opcodes; address MSB first
// (RULE16) Reads stream sequential bytes; fast read dummy
module serial_flash_command_frontend #(
    parameter logic [7:0] MAKER_ID   = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEVICE_ID1 = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEVICE_ID2 = 8'h11  // Arbitrary value
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        chip_select_n,
    input  wire logic        serial_clock,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe,
    input  wire logic [7:0]  status_byte,
    input  wire logic        array_busy,
    input  wire logic        write_done,
    input  wire logic [7:0]  mem_data,
    output logic      [23:0] mem_addr,
    output logic             mem_rd_stb,
    output logic      [3:0]  mem_block,
    output logic      [7:0]  mem_sector,
    output logic             write_latch_flag,
    output logic             status_write_stb,
    output logic      [7:0]  status_write_data,
    output logic             active_mode
);
    logic [5:0] pin_level;
    logic       cs_n_now;
    logic       sclk_now;
    logic [3:0] io_now;
    logic       cs_n_prev_reg;
    logic       sclk_prev_reg;
    logic       cs_fall;
    logic       cs_rise;
    logic       sclk_rise;
    logic       sclk_fall;

    flash_frontend_pkg::frame_state_t state_reg, state_next;
    flash_frontend_pkg::byte_source_t src_reg, src_next;
    logic [7:0]  op_reg, op_next;
    logic [7:0]  in_sh_reg, in_sh_next;
    logic [5:0]  cnt_reg, cnt_next;
    logic [5:0]  dummy_reg, dummy_next;
    logic [3:0]  lanes_reg, lanes_next;
    logic        extra_reg, extra_next;
    logic [23:0] addr_reg, addr_next;
    logic [7:0]  out_sh_reg, out_sh_next;
    logic [3:0]  out_cnt_reg, out_cnt_next;
    logic [1:0]  id_idx_reg, id_idx_next;
    logic [3:0]  io_out_reg, io_out_next;
    logic        wel_reg, wel_next;
    logic        stb_reg, stb_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        rd_stb_reg, rd_stb_next;
    logic [7:0]  opcode_in;
    logic [7:0]  fetch_byte;

    // Take this clock's input bits from the lanes in use
    function automatic logic [3:0] take_bits(input logic [3:0] io, input logic [3:0] lanes);
        logic [3:0] bits;
        bits = io;
        if (lanes == flash_frontend_pkg::LANES_SINGLE) begin
            bits = {3'h0, io[0]};
        end else if (lanes == flash_frontend_pkg::LANES_DUAL) begin
            bits = {2'h0, io[1:0]}; // [RULE14]
        end
        return bits;
    endfunction : take_bits

    // Place the top bits of a byte onto the lanes in use
    function automatic logic [3:0] place_bits(input logic [7:0] sh, input logic [3:0] lanes);
        logic [3:0] bits;
        bits = sh[7:4];
        if (lanes == flash_frontend_pkg::LANES_SINGLE) begin
            bits = {2'h0, sh[7], 1'b0};
        end else if (lanes == flash_frontend_pkg::LANES_DUAL) begin
            bits = {2'h0, sh[7:6]}; // [RULE14]
        end
        return bits;
    endfunction : place_bits

    // Lanes driven during data out
    function automatic logic [3:0] lane_mask(input logic [3:0] lanes);
        logic [3:0] mask;
        mask = 4'hf;
        if (lanes == flash_frontend_pkg::LANES_SINGLE) begin
            mask = 4'h2;
        end else if (lanes == flash_frontend_pkg::LANES_DUAL) begin
            mask = 4'h3;
        end
        return mask;
    endfunction : lane_mask

    pin_filter #(
        .WIDTH (6),
        .IDLE  (flash_frontend_pkg::PIN_IDLE)
    ) u_pin_filter (
        .sys_clk (sys_clk),
        .reset   (reset),
        .pin_in  ({chip_select_n, serial_clock, io_in}),
        .level   (pin_level)
    );

    assign cs_n_now  = pin_level[5];
    assign sclk_now  = pin_level[4];
    assign io_now    = pin_level[3:0];
    assign cs_fall   = cs_n_prev_reg & ~cs_n_now;
    assign cs_rise   = ~cs_n_prev_reg & cs_n_now;
    // Edges are found the same way whatever level the clock idles at [RULE6]
    assign sclk_rise = ~cs_n_now & ~sclk_prev_reg & sclk_now;
    assign sclk_fall = ~cs_n_now & sclk_prev_reg & ~sclk_now;
    assign opcode_in = {in_sh_reg[6:0], io_now[0]};

    always_comb begin
        unique case (src_reg)
            flash_frontend_pkg::SRC_ID: begin
                fetch_byte = (id_idx_reg == 2'h0) ? MAKER_ID :
                             (id_idx_reg == 2'h1) ? DEVICE_ID1 : DEVICE_ID2; // [RULE11]
            end
            flash_frontend_pkg::SRC_STATUS: begin
                fetch_byte = status_byte;
            end
            default: begin
                fetch_byte = mem_data;
            end
        endcase
    end

    always_comb begin
        state_next   = state_reg;
        src_next     = src_reg;
        op_next      = op_reg;
        in_sh_next   = in_sh_reg;
        cnt_next     = cnt_reg;
        dummy_next   = dummy_reg;
        lanes_next   = lanes_reg;
        extra_next   = extra_reg;
        addr_next    = addr_reg;
        out_sh_next  = out_sh_reg;
        out_cnt_next = out_cnt_reg;
        id_idx_next  = id_idx_reg;
        io_out_next  = io_out_reg;
        wel_next     = wel_reg;
        stb_next     = 1'b0;
        wdata_next   = wdata_reg;
        rd_stb_next  = 1'b0;
        if (write_done) begin
            wel_next = 1'b0; // [RULE13]
        end
        if (cs_fall) begin
            state_next   = flash_frontend_pkg::ST_OPCODE; // [RULE2]
            cnt_next     = '0;
            extra_next   = 1'b0;
            out_cnt_next = '0;
            lanes_next   = flash_frontend_pkg::LANES_SINGLE;
        end else if (cs_rise) begin
            // Any frame ends here, read data out included [RULE7] [RULE4]
            if (state_reg == flash_frontend_pkg::ST_WAIT_END && !extra_reg) begin // [RULE8]
                unique case (op_reg)
                    flash_frontend_pkg::WRITE_UNLOCK_CMD: wel_next = 1'b1; // [RULE12]
                    flash_frontend_pkg::WRITE_LOCK_CMD:   wel_next = 1'b0; // [RULE13]
                    default: begin
                        if (wel_reg && !array_busy) begin // [RULE12]
                            stb_next   = 1'b1;
                            wdata_next = in_sh_reg;
                            wel_next   = 1'b0; // [RULE13]
                        end
                    end
                endcase
            end
            state_next = flash_frontend_pkg::ST_IDLE;
        end else if (sclk_rise) begin // [RULE5]
            unique case (state_reg)
                flash_frontend_pkg::ST_OPCODE: begin
                    in_sh_next = opcode_in;
                    cnt_next   = cnt_reg + 6'h1;
                    if (cnt_reg == flash_frontend_pkg::BYTE_BITS - 6'h1) begin
                        op_next     = opcode_in;
                        cnt_next    = '0;
                        id_idx_next = '0;
                        addr_next   = '0;
                        state_next  = flash_frontend_pkg::ST_IGNORE; // [RULE2]
                        unique case (opcode_in) // [RULE15]
                            flash_frontend_pkg::WRITE_UNLOCK_CMD,
                            flash_frontend_pkg::WRITE_LOCK_CMD: begin
                                state_next = flash_frontend_pkg::ST_WAIT_END;
                            end
                            flash_frontend_pkg::STATUS_WRITE_CMD: begin
                                state_next = flash_frontend_pkg::ST_PAYLOAD;
                            end
                            flash_frontend_pkg::JEDEC_ID_READ_CMD: begin
                                src_next   = flash_frontend_pkg::SRC_ID;
                                state_next = flash_frontend_pkg::ST_DATA_OUT;
                            end
                            flash_frontend_pkg::STATUS_READ_CMD: begin
                                src_next   = flash_frontend_pkg::SRC_STATUS;
                                state_next = flash_frontend_pkg::ST_DATA_OUT;
                            end
                            flash_frontend_pkg::READ_CMD,
                            flash_frontend_pkg::FAST_READ_CMD,
                            flash_frontend_pkg::DUAL_IO_READ_CMD,
                            flash_frontend_pkg::QUAD_IO_READ_CMD: begin
                                src_next = flash_frontend_pkg::SRC_ARRAY;
                                unique case (opcode_in)
                                    flash_frontend_pkg::READ_CMD: begin
                                        dummy_next = flash_frontend_pkg::DUMMY_NONE;
                                    end
                                    flash_frontend_pkg::FAST_READ_CMD: begin
                                        dummy_next = flash_frontend_pkg::DUMMY_FAST; // [RULE16]
                                    end
                                    flash_frontend_pkg::DUAL_IO_READ_CMD: begin
                                        dummy_next = flash_frontend_pkg::DUMMY_DUAL;
                                        lanes_next = flash_frontend_pkg::LANES_DUAL; // [RULE14]
                                    end
                                    default: begin
                                        dummy_next = flash_frontend_pkg::DUMMY_QUAD;
                                        lanes_next = flash_frontend_pkg::LANES_QUAD;
                                    end
                                endcase
                                if (!array_busy) begin // [RULE9]
                                    state_next = flash_frontend_pkg::ST_ADDRESS;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                flash_frontend_pkg::ST_ADDRESS: begin
                    // Address arrives most significant bits first [RULE15]
                    addr_next = (addr_reg << lanes_reg) | {20'h0, take_bits(io_now, lanes_reg)};
                    cnt_next  = cnt_reg + {2'h0, lanes_reg};
                    if (cnt_reg + {2'h0, lanes_reg} == flash_frontend_pkg::ADDR_BITS_W) begin
                        cnt_next   = '0;
                        state_next = (dummy_reg == flash_frontend_pkg::DUMMY_NONE) ?
                                     flash_frontend_pkg::ST_DATA_OUT :
                                     flash_frontend_pkg::ST_DUMMY;
                    end
                end
                flash_frontend_pkg::ST_DUMMY: begin
                    cnt_next = cnt_reg + 6'h1;
                    if (cnt_reg + 6'h1 == dummy_reg) begin
                        state_next = flash_frontend_pkg::ST_DATA_OUT;
                    end
                end
                flash_frontend_pkg::ST_PAYLOAD: begin
                    in_sh_next = opcode_in;
                    cnt_next   = cnt_reg + 6'h1;
                    if (cnt_reg == flash_frontend_pkg::BYTE_BITS - 6'h1) begin
                        state_next = flash_frontend_pkg::ST_WAIT_END;
                    end
                end
                flash_frontend_pkg::ST_WAIT_END: begin
                    extra_next = 1'b1; // [RULE8]
                end
                default: begin
                end
            endcase
        end else if (sclk_fall && state_reg == flash_frontend_pkg::ST_DATA_OUT) begin // [RULE5]
            if (out_cnt_reg == 4'h0) begin
                // New byte: read data streams on until select rises [RULE16]
                io_out_next  = place_bits(fetch_byte, lanes_reg);
                out_sh_next  = fetch_byte << lanes_reg;
                out_cnt_next = flash_frontend_pkg::BYTE_BITS[3:0] - lanes_reg;
                id_idx_next  = (id_idx_reg == flash_frontend_pkg::ID_LAST_INDEX) ?
                               2'h0 : id_idx_reg + 2'h1;
                if (src_reg == flash_frontend_pkg::SRC_ARRAY) begin
                    addr_next   = (addr_reg + 24'h1) & flash_frontend_pkg::ARRAY_LAST; // [RULE1]
                    rd_stb_next = 1'b1;
                end
            end else begin
                io_out_next  = place_bits(out_sh_reg, lanes_reg);
                out_sh_next  = out_sh_reg << lanes_reg;
                out_cnt_next = out_cnt_reg - lanes_reg;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cs_n_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
            state_reg     <= flash_frontend_pkg::ST_IDLE;
            src_reg       <= flash_frontend_pkg::SRC_ID;
            op_reg        <= '0;
            in_sh_reg     <= '0;
            cnt_reg       <= '0;
            dummy_reg     <= '0;
            lanes_reg     <= flash_frontend_pkg::LANES_SINGLE;
            extra_reg     <= 1'b0;
            addr_reg      <= '0;
            out_sh_reg    <= '0;
            out_cnt_reg   <= '0;
            id_idx_reg    <= '0;
            io_out_reg    <= '0;
            wel_reg       <= 1'b0; // [RULE13]
            stb_reg       <= 1'b0;
            wdata_reg     <= '0;
            rd_stb_reg    <= 1'b0;
        end else begin
            cs_n_prev_reg <= cs_n_now;
            sclk_prev_reg <= sclk_now;
            state_reg     <= state_next;
            src_reg       <= src_next;
            op_reg        <= op_next;
            in_sh_reg     <= in_sh_next;
            cnt_reg       <= cnt_next;
            dummy_reg     <= dummy_next;
            lanes_reg     <= lanes_next;
            extra_reg     <= extra_next;
            addr_reg      <= addr_next;
            out_sh_reg    <= out_sh_next;
            out_cnt_reg   <= out_cnt_next;
            id_idx_reg    <= id_idx_next;
            io_out_reg    <= io_out_next;
            wel_reg       <= wel_next;
            stb_reg       <= stb_next;
            wdata_reg     <= wdata_next;
            rd_stb_reg    <= rd_stb_next;
        end
    end

    // Pins released outside data out, standby included [RULE3]
    assign io_oe = (state_reg == flash_frontend_pkg::ST_DATA_OUT) ? lane_mask(lanes_reg) : 4'h0;
    assign io_out            = io_out_reg;
    assign mem_addr          = addr_reg & flash_frontend_pkg::ARRAY_LAST; // [RULE1]
    assign mem_block         = mem_addr[flash_frontend_pkg::BLOCK_SHIFT +: 4];
    assign mem_sector        = mem_addr[flash_frontend_pkg::SECTOR_SHIFT +: 8];
    assign mem_rd_stb        = rd_stb_reg;
    assign write_latch_flag  = wel_reg;
    assign status_write_stb  = stb_reg;
    assign status_write_data = wdata_reg;
    assign active_mode = (state_reg != flash_frontend_pkg::ST_IDLE) &&
                         (state_reg != flash_frontend_pkg::ST_IGNORE) &&
                         (state_reg != flash_frontend_pkg::ST_OPCODE); // [RULE4]
endmodule : serial_flash_command_frontend

// ---- sim/serial_flash_command_frontend_properties.sv ----
// Port assertions for the flash command front end
module flash_frontend_checker (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        chip_select_n,
    input wire logic        serial_clock,
    input wire logic [3:0]  io_in,
    input wire logic [3:0]  io_out,
    input wire logic [3:0]  io_oe,
    input wire logic [7:0]  status_byte,
    input wire logic        array_busy,
    input wire logic        write_done,
    input wire logic [7:0]  mem_data,
    input wire logic [23:0] mem_addr,
    input wire logic        mem_rd_stb,
    input wire logic [3:0]  mem_block,
    input wire logic [7:0]  mem_sector,
    input wire logic        write_latch_flag,
    input wire logic        status_write_stb,
    input wire logic [7:0]  status_write_data,
    input wire logic        active_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    map_index_a: assert property (
        mem_block == mem_addr[19:16] && mem_sector == mem_addr[19:12])
        else $error("block or sector index wrong");
    addr_range_a: assert property (mem_addr <= 24'h0fffff)
        else $error("address beyond array");
    idle_release_a: assert property (
        chip_select_n[*8] |-> io_oe == 4'h0 && !active_mode)
        else $error("pins or active mode held after select rise");
    out_on_fall_a: assert property (
        (!chip_select_n && serial_clock)[*8] |-> $stable(io_out))
        else $error("output changed while clock high");
    oe_active_a: assert property (
        io_oe != 4'h0 |-> active_mode || $past(active_mode))
        else $error("output driven in standby");
    sw_latch_a: assert property (
        status_write_stb |-> $past(write_latch_flag) && !write_latch_flag)
        else $error("status write without latch or latch kept");
    latch_frame_a: assert property (
        $rose(write_latch_flag) |-> $past(chip_select_n, 3))
        else $error("latch set before select rise");
    sw_frame_a: assert property (
        status_write_stb |-> $past(chip_select_n, 3))
        else $error("status write before select rise");
    done_clear_a: assert property (
        chip_select_n[*8] ##0 write_done |=> !write_latch_flag)
        else $error("latch kept after write completion");
    rd_advance_a: assert property (
        mem_rd_stb |-> mem_addr == (($past(mem_addr) + 24'h1) & 24'h0fffff))
        else $error("read address did not advance");
endmodule : flash_frontend_checker

bind serial_flash_command_frontend flash_frontend_checker chk (.*);

// ---- sim/flash_host_model.sv ----
// Serial host controller model driving select, clock and data lines
module flash_host_model (
    output logic            chip_select_n,
    output logic            serial_clock,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0]  tx_q[$];
    logic [63:0] rx_data;
    event        done_ev;
    initial begin
        chip_select_n = 1'b1;
        serial_clock  = 1'b0;
        io_in         = 4'h0;
    end
    // Queues n bits of v, lanes bits per clock, top bit on the highest line
    task automatic put(input logic [31:0] v, input int n, input int lanes);
        for (int i = n - lanes; i >= 0; i -= lanes)
            tx_q.push_back(4'(v >> i) & 4'((1 << lanes) - 1));
    endtask : put
    task automatic frame(input bit mode3, input int nout);
        rx_data = '0;
        serial_clock = mode3;
        // Off-grid start keeps every pin change away from clock edges
        #20.3 chip_select_n = 1'b0;
        while (tx_q.size() > 0) begin
            #62.5 serial_clock = 1'b0;
            io_in = tx_q.pop_front();
            #62.5 serial_clock = 1'b1;
        end
        repeat (nout) begin
            #62.5 serial_clock = 1'b0;
            io_in = ~io_in;
            #62.5 serial_clock = 1'b1;
            // Undriven lines read high through pull-ups
            rx_data = io_oe == 4'hf ? {rx_data[59:0], io_out} :
                io_oe == 4'h3 ? {rx_data[61:0], io_out[1:0]} :
                {rx_data[62:0], io_out[1] | ~io_oe[1]};
        end
        #62.5 serial_clock = mode3;
        #20 chip_select_n = 1'b1;
        io_in = ~io_in;
        #150 ->done_ev;
    endtask : frame
endmodule : flash_host_model

// ---- sim/serial_flash_command_frontend_tb.sv ----
// Self-checking bench for the flash command front end
`define CHECK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module serial_flash_command_frontend_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        array_busy = 1'b0;
    logic        write_done = 1'b0;
    logic [7:0]  status_byte = 8'h00;
    logic        chip_select_n, serial_clock, mem_rd_stb, write_latch_flag;
    logic        status_write_stb, active_mode, latch_e;
    logic [3:0]  io_in, io_out, io_oe, mem_block, sw_cnt, sw_cnt_e;
    logic [7:0]  mem_data, mem_sector, status_write_data, sw_data_e, d;
    logic [23:0] mem_addr, addrs[2];
    logic [48:0] exp_q[$], exp_v, got_v;
    logic [7:0]  ops[4] = '{8'h03, 8'h0b, 8'hbb, 8'heb};
    int          lanes[4] = '{1, 1, 2, 4};
    int          dum[4] = '{0, 8, 8, 24};
    int          errors = 0;
    int          checks_done = 0;
    serial_flash_command_frontend dut (.*);
    flash_host_model host (.*);
    assign mem_data = mem_addr[7:0] ^ mem_addr[15:8] ^ {4'h0, mem_addr[19:16]};
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk or posedge reset)
        sw_cnt <= reset ? 4'h0 : sw_cnt + 4'(status_write_stb === 1'b1);
    always @(host.done_ev) begin
        exp_v = exp_q.pop_front();
        got_v = {status_write_data, sw_cnt, write_latch_flag, io_oe, host.rx_data[31:0]};
        `CHECK("frame", exp_v, got_v)
    end
    function automatic logic [31:0] four(input logic [23:0] a);
        logic [23:0] b;
        for (int i = 0; i < 4; i++) begin
            b = 24'(a + i) & 24'h0fffff;
            four = {four[23:0], b[7:0] ^ b[15:8] ^ {4'h0, b[19:16]}};
        end
    endfunction : four
    task automatic run(input bit m3, input int nout, input logic [31:0] dout);
        exp_q.push_back({sw_data_e, sw_cnt_e, latch_e, 4'h0, dout});
        // Lets the checker take the last frame before the next one clears it
        @(negedge sys_clk);
        host.frame(m3, nout);
    endtask : run
    task automatic wcmd(input logic [31:0] v, input int n);
        host.put(v, n, 1);
        run(0, 0, 32'h0);
    endtask : wcmd
    task automatic results();
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    initial begin
        #500us errors++;
        results();
    end
    initial begin
        void'($urandom(32'h15604015));
        {sw_data_e, sw_cnt_e, latch_e} = '0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (8) @(posedge sys_clk);
        for (int m = 0; m < 2; m++) begin
            host.put(32'h9f, 8, 1);
            run(m, 32, 32'h5a3c115a);
        end
        d = 8'($urandom);
        @(posedge sys_clk) status_byte <= d;
        host.put(32'h05, 8, 1);
        run(0, 16, {16'h0, d, d});
        wcmd(32'h0c, 9);
        latch_e = 1'b1;
        wcmd(32'h06, 8);
        wcmd(32'h0400, 16);
        latch_e = 1'b0;
        wcmd(32'h04, 8);
        d = 8'($urandom);
        wcmd({24'h1, d}, 16);
        latch_e = 1'b1;
        wcmd(32'h06, 8);
        {sw_data_e, sw_cnt_e, latch_e} = {d, sw_cnt_e + 4'h1, 1'b0};
        wcmd({24'h1, d}, 16);
        latch_e = 1'b1;
        wcmd(32'h06, 8);
        @(posedge sys_clk) array_busy <= 1'b1;
        wcmd({24'h1, ~d}, 16);
        host.put(32'h03000000, 32, 1);
        run(0, 16, 32'hffff);
        @(posedge sys_clk) array_busy <= 1'b0;
        write_done <= 1'b1;
        @(posedge sys_clk) write_done <= 1'b0;
        latch_e = 1'b0;
        host.put(32'h20000000, 32, 1);
        run(0, 16, 32'hffff);
        addrs = '{24'($urandom), 24'h0fffff};
        foreach (addrs[k]) for (int c = 0; c < 4; c++) begin
            host.put(ops[c], 8, 1);
            host.put(addrs[k], 24, lanes[c]);
            host.put(32'h0, dum[c], lanes[c]);
            run(c[0], 32 / lanes[c], four(addrs[k]));
        end
        #10 results();
    end
endmodule : serial_flash_command_frontend_tb
